// ---- verilog/reset_strap_thermal_trip_ctrl.sv ----
// Overview of operation
// - The reset pin clears all logic at once, with no clock needed.
// - The speed-select pins are caught at reset release; board pulls up.
// - Undriven straps 17..3 read high and straps 20..18 read low.
// - Graphics-busy is low while the graphics engine works.
// - On thermal trip the internal clock enables stop.
// - Thermal trip stays latched until reset.
// - Reset clears the trip, which returns if still too hot.
// - Either low external sensor input starts memory throttling.
// - Host logic runs on the host clock, a quarter of the data rate.
// - Graphics link clocks come from the 100 MHz reference.
// - Video port B uses transmit lanes 0..3 as red, green, blue, clock.
// - Video port C uses lanes 4..7; its red is port B alpha.
// - Video inputs sit on receive lanes 0, 1, 2 and 5.
module reset_strap_thermal_trip_ctrl #(
	parameter int CORE_RATIO = rst_strap_pkg::CORE_DIV
) (
	input  wire logic                             clk,
	input  wire logic                             hub_reset_in_n,
	input  wire logic                             power_good_in,
	input  wire logic [2:0]                       host_speed_select,
	input  wire logic [rst_strap_pkg::STRAP_W-1:0] strapLevel,
	input  wire logic [rst_strap_pkg::STRAP_W-1:0] strapDriven,
	input  wire logic                             gfxEngineBusy,
	input  wire logic                             tempAtTrip,
	input  wire logic [1:0]                       ext_thermal_sense_n,
	input  wire logic                             gfxRefClkPresent,
	input  wire logic                             videoBEnable,
	input  wire logic                             videoCEnable,
	input  wire logic [3:0]                       videoBTx,
	input  wire logic [3:0]                       videoCTx,
	input  wire logic [rst_strap_pkg::LANES-1:0]  pcieTx,
	input  wire logic [rst_strap_pkg::LANES-1:0]  laneRx,
	output logic [2:0]                            hostSpeed,
	output logic [rst_strap_pkg::STRAP_W-1:0]     strapValue,
	output logic                                  strapsValid,
	output logic                                  graphics_busy_n,
	output logic                                  thermal_trip_n,
	output logic                                  coreClkEn,
	output logic                                  pcieClkEn,
	output logic                                  memThrottle,
	output logic [rst_strap_pkg::LANES-1:0]       laneTx,
	output logic [rst_strap_pkg::LANES-1:0]       pcieRx,
	output logic [3:0]                            videoRx
);
	import rst_strap_pkg::*;

	// ==========================================================
	// strap capture
	// pins are caught on the first edge after release, never by the
	// asynchronous reset itself
	logic [STRAP_W-1:0] strapPin;
	logic               captured_q;

	for (genvar i = 0; i < STRAP_W; i++) begin : g_strap
		localparam logic PULL = STRAP_RESET[i];
		assign strapPin[i] = strapDriven[i] ? strapLevel[i] : PULL;
	end

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			captured_q <= 1'b0;
			strapsValid <= 1'b0;
			hostSpeed <= SPEED_RESET;
			strapValue <= STRAP_RESET;
		end else if (!captured_q) begin
			captured_q <= 1'b1;
			strapsValid <= 1'b1;
			hostSpeed <= host_speed_select;
			strapValue <= strapPin;
		end
	end

	// ==========================================================
	// thermal trip
	tripState_t tripState_q;

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			tripState_q <= TRIP_RUN;
			thermal_trip_n <= 1'b1;
		end else begin
			unique case (tripState_q)
				TRIP_RUN: begin
					if (tempAtTrip) begin
						tripState_q <= TRIP_HALT;
						thermal_trip_n <= 1'b0;
					end
				end
				TRIP_HALT: begin
					// only reset leaves this state
					tripState_q <= TRIP_HALT;
					thermal_trip_n <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// internal clock enables from the host clock
	// clk is the host reference; core rate is a divided enable
	localparam int DIV_W = $clog2(CORE_RATIO + 1);
	logic [DIV_W-1:0] divCnt_q;
	logic             running;

	assign running = power_good_in && tripState_q == TRIP_RUN
		&& !tempAtTrip;

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			divCnt_q <= '0;
			coreClkEn <= 1'b0;
		end else if (!running) begin
			divCnt_q <= '0;
			coreClkEn <= 1'b0;
		end else if (divCnt_q == DIV_W'(CORE_RATIO - 1)) begin
			divCnt_q <= '0;
			coreClkEn <= 1'b1;
		end else begin
			divCnt_q <= divCnt_q + 1'b1;
			coreClkEn <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			pcieClkEn <= 1'b0;
		end else begin
			pcieClkEn <= running && gfxRefClkPresent;
		end
	end

	// ==========================================================
	// busy and memory throttle
	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			graphics_busy_n <= 1'b1;
		end else begin
			graphics_busy_n <= !gfxEngineBusy;
		end
	end

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			memThrottle <= 1'b0;
		end else begin
			memThrottle <= !(&ext_thermal_sense_n);
		end
	end

	// ==========================================================
	// shared lanes
	// registered so each pad sees a flop; costs one cycle of latency
	lane_if lanes ();

	assign lanes.videoB = videoBEnable;
	assign lanes.videoC = videoCEnable;
	assign lanes.videoBTx = videoBTx;
	assign lanes.videoCTx = videoCTx;
	assign lanes.pcieTx = pcieTx;
	assign lanes.laneRx = laneRx;

	lane_mux u_lane_mux (
		.lanes (lanes.mux)
	);

	always_ff @(posedge clk or negedge hub_reset_in_n) begin
		if (!hub_reset_in_n) begin
			laneTx <= '0;
			pcieRx <= '0;
			videoRx <= 4'h0;
		end else begin
			laneTx <= lanes.laneTx;
			pcieRx <= lanes.pcieRx;
			videoRx <= lanes.videoRx;
		end
	end

	// ==========================================================
	// checks
	a_trip_latched: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		!thermal_trip_n |=> !thermal_trip_n)
		else $error("thermal trip released without reset");

	a_trip_sets: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		tempAtTrip |=> !thermal_trip_n)
		else $error("thermal trip not raised when hot");

	a_clocks_stop: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		!thermal_trip_n |-> !coreClkEn && !pcieClkEn)
		else $error("clock enable active after trip");

	a_core_pace: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		coreClkEn && running |=> !coreClkEn)
		else $error("core enable wider than one cycle");

	a_speed_caught: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		!captured_q |=> hostSpeed == $past(host_speed_select)
			&& strapsValid)
		else $error("speed select not sampled at release");

	a_strap_hold: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		strapsValid |=> $stable(strapValue) && $stable(hostSpeed))
		else $error("strap value changed after capture");

	a_busy_follow: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		gfxEngineBusy |=> !graphics_busy_n)
		else $error("busy output missed engine activity");

	a_mem_throttle: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		ext_thermal_sense_n != 2'h3 |=> memThrottle)
		else $error("throttle not started by sensor");

	a_lane_b_map: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		videoBEnable |=> laneTx[TX_B_CLK:TX_B_RED] == $past(videoBTx))
		else $error("port B lanes misrouted");

	a_lane_c_map: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		videoCEnable |=> laneTx[TX_C_CLK:TX_C_RED] == $past(videoCTx))
		else $error("port C lanes misrouted");

	a_rx_split: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		videoBEnable |=> videoRx[0] == $past(laneRx[RX_TV_CLK])
			&& pcieRx[RX_FSTALL] == 1'b0)
		else $error("video receive lanes misrouted");

	a_pcie_own: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		!videoBEnable && !videoCEnable |=> laneTx == $past(pcieTx)
			&& videoRx == 4'h0)
		else $error("lane not given to graphics link");

	a_pcie_ref: assert property (@(posedge clk)
		disable iff (!hub_reset_in_n)
		!gfxRefClkPresent |=> !pcieClkEn)
		else $error("link clock enable without reference");

endmodule // reset_strap_thermal_trip_ctrl

// ---- verilog/rst_strap_pkg.sv ----
package rst_strap_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS     = 100;
	localparam int POWER_STABLE_US   = 10;
	localparam int POWER_STABLE_CYC  =
		(POWER_STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_DATA_PER_CLK = 4;
	localparam int GFX_REF_MHZ       = 100;
	localparam int CORE_DIV          = 2;

	// ==========================================================
	// straps
	localparam int              STRAP_LSB   = 3;
	localparam int              STRAP_MSB   = 20;
	localparam int              STRAP_W     = STRAP_MSB - STRAP_LSB + 1;
	localparam int              PULLUP_MSB  = 17;
	localparam logic [17:0]     STRAP_RESET = 18'h07FFF;
	localparam logic [2:0]      SPEED_RESET = 3'h7;

	// ==========================================================
	// shared lanes
	localparam int LANES     = 8;
	localparam int TX_B_RED  = 0;
	localparam int TX_B_GRN  = 1;
	localparam int TX_B_BLU  = 2;
	localparam int TX_B_CLK  = 3;
	localparam int TX_C_RED  = 4;
	localparam int TX_C_GRN  = 5;
	localparam int TX_C_BLU  = 6;
	localparam int TX_C_CLK  = 7;
	localparam int RX_TV_CLK = 0;
	localparam int RX_B_IRQ  = 1;
	localparam int RX_FSTALL = 2;
	localparam int RX_C_IRQ  = 5;

	typedef enum logic {
		TRIP_RUN  = 1'b0,
		TRIP_HALT = 1'b1
	} tripState_t;

endpackage

// ---- verilog/lane_if.sv ----
interface lane_if;
	import rst_strap_pkg::*;

	logic              videoB;
	logic              videoC;
	logic [3:0]        videoBTx;
	logic [3:0]        videoCTx;
	logic [LANES-1:0]  pcieTx;
	logic [LANES-1:0]  laneRx;
	logic [LANES-1:0]  laneTx;
	logic [LANES-1:0]  pcieRx;
	logic [3:0]        videoRx;

	modport ctrl (
		output videoB, videoC, videoBTx, videoCTx, pcieTx, laneRx,
		input  laneTx, pcieRx, videoRx
	);
	modport mux (
		input  videoB, videoC, videoBTx, videoCTx, pcieTx, laneRx,
		output laneTx, pcieRx, videoRx
	);
endinterface

// ---- verilog/lane_mux.sv ----
// each lane carries the positive leg of its pair; the complement
// follows it in the pad ring
module lane_mux (
	lane_if.mux lanes
);
	import rst_strap_pkg::*;

	// ==========================================================
	// transmit lanes: video port B on 0..3, port C on 4..7
	always_comb begin
		lanes.laneTx = lanes.pcieTx;
		if (lanes.videoB) begin
			lanes.laneTx[TX_B_RED] = lanes.videoBTx[0];
			lanes.laneTx[TX_B_GRN] = lanes.videoBTx[1];
			lanes.laneTx[TX_B_BLU] = lanes.videoBTx[2];
			lanes.laneTx[TX_B_CLK] = lanes.videoBTx[3];
		end
		if (lanes.videoC) begin
			// lane 4 also serves as port B alpha
			lanes.laneTx[TX_C_RED] = lanes.videoCTx[0];
			lanes.laneTx[TX_C_GRN] = lanes.videoCTx[1];
			lanes.laneTx[TX_C_BLU] = lanes.videoCTx[2];
			lanes.laneTx[TX_C_CLK] = lanes.videoCTx[3];
		end
	end

	// ==========================================================
	// receive lanes: a lane owned by video is hidden from the
	// graphics link so neither side sees the other's traffic
	always_comb begin
		lanes.pcieRx = lanes.laneRx;
		lanes.videoRx = 4'h0;
		if (lanes.videoB) begin
			lanes.videoRx[0] = lanes.laneRx[RX_TV_CLK];
			lanes.videoRx[1] = lanes.laneRx[RX_B_IRQ];
			lanes.videoRx[2] = lanes.laneRx[RX_FSTALL];
			lanes.pcieRx[RX_TV_CLK] = 1'b0;
			lanes.pcieRx[RX_B_IRQ] = 1'b0;
			lanes.pcieRx[RX_FSTALL] = 1'b0;
		end
		if (lanes.videoC) begin
			lanes.videoRx[3] = lanes.laneRx[RX_C_IRQ];
			lanes.pcieRx[RX_C_IRQ] = 1'b0;
		end
	end
endmodule // lane_mux

// ---- verification/platform_hub_model.sv ----
// ==========================================================
// stand-in for the platform I/O hub and the clock synthesizer
module platform_hub_model
	import rst_strap_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetReq,
	input  wire logic coreOn,
	input  wire logic thermal_trip_n,
	output logic      hub_reset_in_n,
	output logic      power_good_in,
	output logic      gfxRefClkPresent
);
	timeunit 1ns;
	timeprecision 1ns;

	int   stableCnt = 0;
	logic powerOn;

	assign hub_reset_in_n = !resetReq;
	// a trip makes the platform pull core power, so power-good drops too
	assign powerOn = coreOn && thermal_trip_n;
	assign power_good_in = stableCnt >= POWER_STABLE_CYC;
	assign gfxRefClkPresent = coreOn;

	always @(posedge clk) begin
		if (powerOn === 1'b1)
			stableCnt <= stableCnt + int'(stableCnt < POWER_STABLE_CYC);
		else
			stableCnt <= 0;
	end
endmodule // platform_hub_model

// ---- verification/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rst_strap_pkg::*;

	localparam int RATIO = 2;
	localparam int DLY   = 10;

	logic               clk = 1'b0;
	logic               resetReq = 1'b1;
	logic               coreOn = 1'b1;
	logic [2:0]         host_speed_select = 3'h5;
	logic [STRAP_W-1:0] strapLevel = 18'h10000;
	logic [STRAP_W-1:0] strapDriven = 18'h30081;
	logic               gfxEngineBusy = 1'b0;
	logic               tempAtTrip = 1'b0;
	logic [1:0]         ext_thermal_sense_n = 2'h3;
	logic               videoBEnable = 1'b0;
	logic               videoCEnable = 1'b0;
	logic [3:0]         videoBTx = 4'h0;
	logic [3:0]         videoCTx = 4'h0;
	logic [LANES-1:0]   pcieTx = 8'h00;
	logic [LANES-1:0]   laneRx = 8'h00;
	logic               hub_reset_in_n, power_good_in, gfxRefClkPresent;
	logic               strapsValid, graphics_busy_n, thermal_trip_n;
	logic               coreClkEn, pcieClkEn, memThrottle;
	logic [2:0]         hostSpeed;
	logic [STRAP_W-1:0] strapValue;
	logic [LANES-1:0]   laneTx, pcieRx;
	logic [3:0]         videoRx;
	int                 n_mismatch = 0;
	int                 comparisons = 0;
	int                 cycles = 0;

	always #50 clk = ~clk;

	platform_hub_model hub (.clk, .resetReq, .coreOn, .thermal_trip_n,
		.hub_reset_in_n, .power_good_in, .gfxRefClkPresent);

	reset_strap_thermal_trip_ctrl #(.CORE_RATIO(RATIO)) dut (.clk,
		.hub_reset_in_n, .power_good_in, .host_speed_select, .strapLevel,
		.strapDriven, .gfxEngineBusy, .tempAtTrip, .ext_thermal_sense_n,
		.gfxRefClkPresent, .videoBEnable, .videoCEnable, .videoBTx,
		.videoCTx, .pcieTx, .laneRx, .hostSpeed, .strapValue, .strapsValid,
		.graphics_busy_n, .thermal_trip_n, .coreClkEn, .pcieClkEn,
		.memThrottle, .laneTx, .pcieRx, .videoRx);

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#DLY;
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic t_straps;
		check("validInReset", strapsValid, 1'b0);
		check("speedInReset", hostSpeed, 3'h7);
		check("strapsInReset", strapValue, 18'h07FFF);
		resetReq = 1'b0;
		cyc(1);
		check("valid", strapsValid, 1'b1);
		check("speed", hostSpeed, 3'h5);
		// driven: bit 16 high, bits 0, 7, 17 low; the rest pulled
		check("straps", strapValue, 18'h17F7E);
		// later pin moves must not disturb the captured values
		host_speed_select = 3'h2;
		strapLevel = ~strapLevel;
		cyc(2);
		check("speedHeld", hostSpeed, 3'h5);
		check("strapsHeld", strapValue, 18'h17F7E);
	endtask

	task automatic t_busy;
		gfxEngineBusy = 1'b1;
		cyc(1);
		check("busy", graphics_busy_n, 1'b0);
		gfxEngineBusy = 1'b0;
		cyc(1);
		check("idle", graphics_busy_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ext_thermal_sense_n = 2'(i);
			cyc(1);
			check("throttle", memThrottle, 1'(i != 3));
		end
	endtask

	task automatic t_lanes;
		videoBEnable = 1'b1;
		videoCEnable = 1'b1;
		videoBTx = 4'hA;
		videoCTx = 4'h5;
		pcieTx = 8'hFF;
		laneRx = 8'h21;
		cyc(1);
		check("videoTx", laneTx, 8'h5A);
		check("videoRx", videoRx, 4'h9);
		check("pcieRxOff", pcieRx, 8'h00);
		// port B alone: lanes 4..7 stay with the graphics link
		videoCEnable = 1'b0;
		videoBTx = 4'h6;
		pcieTx = 8'h9F;
		cyc(1);
		check("bOnlyTx", laneTx, 8'h96);
		check("bOnlyRx", videoRx, 4'h1);
		check("bOnlyPcieRx", pcieRx, 8'h20);
		videoBEnable = 1'b0;
		pcieTx = 8'hC3;
		cyc(1);
		check("pcieTx", laneTx, 8'hC3);
		check("pcieRx", pcieRx, 8'h21);
		check("videoRxOff", videoRx, 4'h0);
	endtask

	task automatic wait_power;
		int n;
		n = 0;
		while (power_good_in !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		check("powerGood", power_good_in, 1'b1);
	endtask

	task automatic t_clocks;
		int n;
		wait_power();
		cyc(2);
		check("pcieClk", pcieClkEn, 1'b1);
		n = 0;
		repeat (8) begin
			cyc(1);
			n += int'(coreClkEn === 1'b1);
		end
		check("corePulses", n, 8 / RATIO);
		// losing the reference stops the link clock on the next edge
		coreOn = 1'b0;
		cyc(1);
		check("pcieNoRef", pcieClkEn, 1'b0);
		cyc(1);
		check("coreNoPower", coreClkEn, 1'b0);
		coreOn = 1'b1;
		wait_power();
		cyc(2);
	endtask

	task automatic t_trip;
		tempAtTrip = 1'b1;
		cyc(1);
		check("trip", thermal_trip_n, 1'b0);
		check("coreStop", coreClkEn, 1'b0);
		check("pcieStop", pcieClkEn, 1'b0);
		tempAtTrip = 1'b0;
		cyc(4);
		check("tripHeld", thermal_trip_n, 1'b0);
		// assert reset between edges: the clear must not wait for one
		tempAtTrip = 1'b1;
		resetReq = 1'b1;
		#5;
		check("asyncClear", thermal_trip_n, 1'b1);
		cyc(2);
		resetReq = 1'b0;
		cyc(1);
		check("reTrip", thermal_trip_n, 1'b0);
		tempAtTrip = 1'b0;
		resetReq = 1'b1;
		cyc(2);
		resetReq = 1'b0;
		cyc(2);
		check("coolStart", thermal_trip_n, 1'b1);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		#DLY;
		t_straps();
		t_busy();
		t_lanes();
		t_clocks();
		t_trip();
		stop_test();
	end
endmodule // tb_top
